//--- shared/twl_pkg.sv
// twl_pkg: constants and types for the two-wire converter load host
// assumes: 25 MHz system clock; link clock made here by a divider
package twl_pkg;
   localparam int WORD_W        = 12;
   localparam int CNT_W         = 4;
   localparam int FIFO_DEPTH    = 32;
   localparam int SEL_W         = 2;
   localparam int CLK_HZ        = 25_000_000;
   // power-up clear hold, in microseconds
   localparam int CLR_TIME_US   = 10_000;
   localparam int CLR_CYCLES    = CLR_TIME_US * (CLK_HZ / 1_000_000);
   // half period of the line clock, in system clocks
   localparam logic [3:0] HALF_DIV     = 4'h4;
   localparam logic [3:0] LAST_BIT     = 4'hb;
   localparam logic [3:0] LOAD_COUNT   = 4'hc;
   localparam logic [3:0] CNT_RELOAD   = 4'h0;
   localparam logic [3:0] SETTLE_HALVES = 4'h3;
   typedef logic [WORD_W-1:0] twl_word_t;
   typedef enum logic [2:0]
   {
      TWL_CLEAR  = 3'b000,
      TWL_IDLE   = 3'b001,
      TWL_SETUP  = 3'b010,
      TWL_LOW    = 3'b011,
      TWL_HIGH   = 3'b100,
      TWL_STROBE = 3'b101,
      TWL_SELECT = 3'b110
   } twl_state_e;
endpackage

//--- shared/twl_stream_if.sv
// twl_stream_if: valid/ready word stream between fifo and sequencer
// assumes: both ends share one clock
`timescale 1ns/1ps
interface twl_stream_if;
   import twl_pkg::*;
   logic                    valid;
   logic                    ready;
   logic [WORD_W+SEL_W:0]   data;
   modport source
   (
      output valid,
      output data,
      input  ready
   );
   modport sink
   (
      input  valid,
      input  data,
      output ready
   );
endinterface

//--- core/twl_fifo.sv
// twl_fifo: parameterised synchronous fifo with valid/ready on both sides
// assumes: single clock, synchronous active-high reset
`timescale 1ns/1ps
module twl_fifo
#(
   parameter int WIDTH = 15,
   parameter int DEPTH = 32
)
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   twl_stream_if.source          out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic [AW:0]      fill;
   logic             push;
   logic             pop;

   assign inReady   = (fill != (AW+1)'(DEPTH));
   assign out.valid = (fill != '0);
   assign out.data  = mem[rdPtr];
   assign push      = inValid && inReady;
   assign pop       = out.valid && out.ready;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
         fill  <= '0;
      end
      else
      begin
         if (push)
         begin
            wrPtr <= wrPtr + AW'(1);
         end
         if (pop)
         begin
            rdPtr <= rdPtr + AW'(1);
         end
         fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

//--- core/twl_host.sv
// twl_host: host that loads serial 12-bit converters over two lines
// assumes: adapter counter and converters sit outside; pins registered except wordReady
//
// How it works
// RULE_01: adapter counter advances on each rising line clock edge.
// RULE_02: adapter inverts line clock; converter shifts on falling edges.
// RULE_03: after twelfth bit the adapter count reads 1011.
// RULE_04: next rising edge gives 1100, adapter drives load strobe low.
// RULE_05: load strobe also reloads the counter, blocking a thirteenth shift.
// RULE_06: after last word, line clock stops high after thirteenth pulse.
// RULE_07: another word repeats the same thirteen-pulse sequence.
// RULE_08: power-on clear holds counter and converters for 10 ms.
// RULE_09: shared data; select only the target converter to transfer.
// RULE_10: select decoder enable inactive while address changes.
// RULE_11: clear during power-up forces outputs to zero scale.
// RULE_12: three-line variant ties select low; data, clock, strobe cross.
// RULE_13: window limits loaded into separate converters by limit select.
// RULE_14: converter copies shift register on load strobe low.
// RULE_15: extra bits push out oldest bits; last twelve kept.
// RULE_16: clear acts asynchronously, forcing output to zero.
// RULE_17: line clock already high before select deasserts.
// RULE_18: adapter counter four bits, reload value zero.
// RULE_19: words sent msb first, natural binary, one bit per pulse.
`timescale 1ns/1ps
module twl_host
   import twl_pkg::*;
#(
   parameter int CLEAR_CYCLES = twl_pkg::CLR_CYCLES
)
(
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 wordValid,
   output logic                      wordReady,
   input  wire twl_pkg::twl_word_t   wordData,
   input  wire logic [SEL_W-1:0]     wordAddr,
   input  wire logic                 wordLimitHigh,
   input  wire logic                 lineClkIn,
   output logic                      lineClk,
   output logic                      serialBitOut,
   output logic                      zeroOutput_n,
   output logic [SEL_W-1:0]          decodeAddr,
   output logic                      decodeEnable_n,
   output logic                      limitChannelSelect,
   output logic                      busy
);
   twl_stream_if q ();

   twl_state_e            state;
   twl_state_e            next_state;
   logic [31:0]           clearCount;
   logic [3:0]            divCount;
   logic                  halfTick;
   logic [3:0]            bitCount;
   logic [3:0]            settle;
   twl_word_t             shiftWord;
   logic                  echoMeta;
   logic                  echoSync;
   logic                  frameLast;
   logic                  inFrameNext;

   twl_fifo #(.WIDTH(WORD_W + SEL_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk     (clk),
      .rst     (rst),
      .inValid (wordValid),
      .inReady (wordReady),
      .inData  ({wordLimitHigh, wordAddr, wordData}),
      .out     (q.source)
   );

   // line clock echo passes two flops before any use
   always_ff @(posedge clk)
   begin
      echoMeta <= lineClkIn;
      echoSync <= echoMeta;
   end

   // divider that makes the line clock
   always_ff @(posedge clk)
   begin
      if (rst || state == TWL_IDLE || state == TWL_CLEAR)
      begin
         divCount <= '0;
      end
      else if (halfTick)
      begin
         divCount <= '0;
      end
      else
      begin
         divCount <= divCount + 4'h1;
      end
   end
   assign halfTick = (divCount == HALF_DIV - 4'h1);

   // power-on clear hold
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         clearCount <= '0;
      end
      else if (state == TWL_CLEAR)
      begin
         clearCount <= clearCount + 32'h1;
      end
   end

   assign q.ready   = (state == TWL_IDLE);
   assign frameLast = (bitCount == CNT_RELOAD); // RULE_05 RULE_06

   always_comb
   begin
      next_state = state;
      case (state)
         TWL_CLEAR:
            if (clearCount >= 32'(CLEAR_CYCLES - 1))
            begin
               next_state = TWL_IDLE; // RULE_08
            end
         TWL_IDLE:
            if (q.valid)
            begin
               next_state = TWL_SETUP;
            end
         TWL_SETUP:
            if (halfTick && settle == SETTLE_HALVES)
            begin
               next_state = TWL_LOW; // RULE_10
            end
         TWL_LOW:
            if (halfTick)
            begin
               next_state = TWL_HIGH; // RULE_01
            end
         TWL_HIGH:
            if (halfTick)
            begin
               next_state = frameLast ? TWL_STROBE : TWL_LOW;
            end
         TWL_STROBE:
            if (halfTick && echoSync)
            begin
               next_state = TWL_SELECT; // RULE_17
            end
         TWL_SELECT:
            if (halfTick)
            begin
               next_state = TWL_IDLE; // RULE_07
            end
         default:
            next_state = TWL_CLEAR;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state <= TWL_CLEAR;
      end
      else
      begin
         state <= next_state;
      end
   end

   // settle counter for address before enable
   always_ff @(posedge clk)
   begin
      if (rst || state != TWL_SETUP)
      begin
         settle <= '0;
      end
      else if (halfTick)
      begin
         settle <= settle + 4'h1;
      end
   end

   // pulse count mirrors adapter counter, wraps to reload on 13th pulse
   always_ff @(posedge clk)
   begin
      if (rst || state == TWL_IDLE)
      begin
         bitCount <= CNT_RELOAD; // RULE_18
      end
      else if (state == TWL_LOW && halfTick)
      begin
         if (bitCount == LOAD_COUNT)
         begin
            bitCount <= CNT_RELOAD; // RULE_05
         end
         else
         begin
            bitCount <= bitCount + 4'h1; // RULE_03 RULE_04
         end
      end
   end

   // word shifter, msb first
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         shiftWord <= '0;
      end
      else if (state == TWL_IDLE && q.valid)
      begin
         shiftWord <= {q.data[WORD_W-2:0], 1'b0};
      end
      else if (state == TWL_LOW && halfTick)
      begin
         shiftWord <= {shiftWord[WORD_W-2:0], 1'b0};
      end
   end

   // data pin, changes only while line clock rises or rests high
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         serialBitOut <= 1'b0;
      end
      else if (state == TWL_IDLE && q.valid)
      begin
         serialBitOut <= q.data[WORD_W-1]; // RULE_19
      end
      else if (state == TWL_LOW && halfTick)
      begin
         serialBitOut <= shiftWord[WORD_W-1]; // RULE_02 RULE_19
      end
   end

   // line clock pin, rests high, low only in LOW state
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         lineClk <= 1'b1;
      end
      else
      begin
         lineClk <= (next_state != TWL_LOW); // RULE_02 RULE_06 RULE_12
      end
   end

   // shared clear line, low through the clear phase
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         zeroOutput_n <= 1'b0;
      end
      else
      begin
         zeroOutput_n <= (state != TWL_CLEAR); // RULE_08
      end
   end

   // busy flag
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         busy <= 1'b0;
      end
      else
      begin
         busy <= (state != TWL_IDLE);
      end
   end

   // decoder address and limit select, latched with the word
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         decodeAddr         <= '0;
         limitChannelSelect <= 1'b0;
      end
      else if (state == TWL_IDLE && q.valid)
      begin
         decodeAddr         <= q.data[WORD_W+SEL_W-1:WORD_W]; // RULE_09
         limitChannelSelect <= q.data[WORD_W+SEL_W]; // RULE_13
      end
   end

   // decoder enable, low only while the address is stable
   assign inFrameNext = (next_state == TWL_LOW)
                        || (next_state == TWL_HIGH)
                        || (next_state == TWL_STROBE);
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         decodeEnable_n <= 1'b1;
      end
      else
      begin
         decodeEnable_n <= !inFrameNext; // RULE_10
      end
   end
endmodule

//--- verification/twl_host_assertions.sv
// twl_host_assertions: port checks on the host
// assumes: bound into twl_host by the bind below
`timescale 1ns/1ps
module twl_host_assertions
   import twl_pkg::*;
#(
   parameter int CLEAR_CYCLES = 20
)
(
   input wire logic                      clk,
   input wire logic                      rst,
   input wire logic                      lineClk,
   input wire logic                      serialBitOut,
   input wire logic                      zeroOutput_n,
   input wire logic [twl_pkg::SEL_W-1:0] decodeAddr,
   input wire logic                      decodeEnable_n,
   input wire logic                      limitChannelSelect,
   input wire logic                      busy
);
   int         lowCnt;
   logic [3:0] pulseCnt;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   always_ff @(posedge clk)
      lowCnt <= (rst || zeroOutput_n) ? 0 : lowCnt + 1;
   always_ff @(posedge clk)
      pulseCnt <= (rst || decodeEnable_n) ? 4'h0
                  : pulseCnt + 4'($fell(lineClk));
   a_reset_state: assert property ($fell(rst) |->
      !zeroOutput_n && lineClk && decodeEnable_n) else $error("reset state");
   a_clear_len: assert property ($rose(zeroOutput_n) |->
      lowCnt >= CLEAR_CYCLES - 1) else $error("clear too short");
   a_idle_high: assert property (!busy |-> lineClk)
      else $error("line clock low while idle");
   a_low_half: assert property ($fell(lineClk) |->
      !lineClk [*4] ##1 lineClk) else $error("low half not 4 cycles");
   a_data_hold: assert property (!lineClk |->
      $stable(serialBitOut)) else $error("data moved while clock low");
   a_addr_guard: assert property ($changed(decodeAddr)
      || $changed(limitChannelSelect) |-> decodeEnable_n
      && $past(decodeEnable_n)) else $error("address moved while enabled");
   a_pulse_gate: assert property ($fell(lineClk) |->
      zeroOutput_n && !decodeEnable_n) else $error("pulse outside frame");
   a_pulse_count: assert property ($rose(decodeEnable_n) |->
      pulseCnt == 4'hd && lineClk) else $error("frame not 13 pulses");
endmodule
bind twl_host twl_host_assertions #(.CLEAR_CYCLES(CLEAR_CYCLES)) u_chk
(
   .clk, .rst, .lineClk, .serialBitOut, .zeroOutput_n, .decodeAddr,
   .decodeEnable_n, .limitChannelSelect, .busy
);

//--- verification/twl_dac_model.sv
// twl_dac_model: two-wire adapter counter, four serial converters and two limit converters
// assumes: driven by twl_host pins; clear is the shared power-on line
`timescale 1ns/1ps
module twl_dac_model
   import twl_pkg::*;
(
   input  wire logic                      lineClk,
   input  wire logic                      serialBitOut,
   input  wire logic                      zeroOutput_n,
   input  wire logic [twl_pkg::SEL_W-1:0] decodeAddr,
   input  wire logic                      decodeEnable_n,
   input  wire logic                      limitChannelSelect,
   output twl_pkg::twl_word_t             outWord [4],
   output twl_pkg::twl_word_t             limitWord [2]
);
   logic [3:0] count;
   twl_word_t  shiftReg;
   logic       loadStrobe_n;
   assign loadStrobe_n = (count != LOAD_COUNT);
   always @(posedge lineClk or negedge zeroOutput_n)
      if (!zeroOutput_n || !loadStrobe_n)
         count <= CNT_RELOAD;
      else
         count <= count + 4'h1;
   always @(negedge lineClk)
      if (loadStrobe_n)
         shiftReg <= {shiftReg[WORD_W-2:0], serialBitOut};
   always @(negedge loadStrobe_n or negedge zeroOutput_n)
      if (!zeroOutput_n)
      begin
         outWord <= '{default: '0};
         limitWord <= '{default: '0};
      end
      else if (!decodeEnable_n)
      begin
         outWord[decodeAddr] <= shiftReg;
         limitWord[limitChannelSelect] <= shiftReg;
      end
endmodule

//--- verification/tb_top.sv
// tb_top: bench for twl_host against the converter model
// assumes: line clock looped back; short clear via CLEAR_CYCLES
`timescale 1ns/1ps
module tb_top;
   import twl_pkg::*;
   logic             clk, rst, wordValid, wordReady, wordLimitHigh;
   logic             lineClk, serialBitOut, zeroOutput_n, busy;
   logic             decodeEnable_n, limitChannelSelect;
   logic [SEL_W-1:0] wordAddr, decodeAddr;
   twl_word_t        wordData, outWord [4], limitWord [2];
   twl_word_t        expOut [4], expLim [2];
   int               n_mismatch, checks;
   twl_host #(.CLEAR_CYCLES(20)) DUT
   (
      .clk, .rst, .wordValid, .wordReady, .wordData, .wordAddr,
      .wordLimitHigh, .lineClkIn(lineClk), .lineClk, .serialBitOut,
      .zeroOutput_n, .decodeAddr, .decodeEnable_n, .limitChannelSelect,
      .busy
   );
   twl_dac_model u_dac
   (
      .lineClk, .serialBitOut, .zeroOutput_n, .decodeAddr,
      .decodeEnable_n, .limitChannelSelect, .outWord, .limitWord
   );
   task automatic chk(input string nm, input twl_word_t e, twl_word_t g);
      checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_all();
      for (int i = 0; i < 4; i++)
         chk("converter word", expOut[i], outWord[i]);
      for (int i = 0; i < 2; i++)
         chk("limit word", expLim[i], limitWord[i]);
   endtask
   task automatic push(input twl_word_t d, input int a, input logic h);
      wordData = d;
      wordAddr = a[1:0];
      wordLimitHigh = h;
      wordValid = 1'b1;
      expOut[a] = d;
      expLim[h] = d;
      while (wordReady !== 1'b1)
         @(negedge clk);
      @(negedge clk);
   endtask
   task automatic wait_idle();
      int q;
      q = 0;
      wordValid = 1'b0;
      for (int k = 0; k < 20000 && q < 40; k++)
      begin
         @(negedge clk);
         q = (busy === 1'b0) ? q + 1 : 0;
      end
      chk("idle reached", 12'h1, twl_word_t'(q >= 40));
   endtask
   task automatic do_reset();
      rst = 1'b1;
      repeat (3) @(negedge clk);
      chk("clear line", 12'h0, twl_word_t'(zeroOutput_n));
      rst = 1'b0;
      expOut = '{default: 12'h0};
      expLim = '{default: 12'h0};
      chk_all();
   endtask
   task automatic t_every();
      twl_word_t tbl [4] = '{12'h7ff, 12'h801, 12'h000, 12'hfff};
      push(12'ha5c, 2, 1'b1);
      wait_idle();
      chk_all();
      for (int a = 0; a < 4; a++)
         push(tbl[a], a, a[0]);
      wait_idle();
      chk_all();
   endtask
   task automatic t_reclear();
      push(12'h3c3, 3, 1'b0);
      wordValid = 1'b0;
      repeat (60) @(negedge clk);
      do_reset();
      wait_idle();
      chk_all();
   endtask
   task automatic t_fill();
      int n;
      n = 0;
      while (wordReady === 1'b1 && n < 40)
      begin
         push(twl_word_t'(n * 37 + 5), n % 4, n[0]);
         n++;
      end
      chk("refused at", 12'h1, twl_word_t'(n >= 32 && n <= 34));
      wait_idle();
      chk_all();
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial
   begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      test_done();
   end
   initial
   begin
      wordValid = 1'b0;
      wordData = 12'h0;
      wordAddr = 2'h0;
      wordLimitHigh = 1'b0;
      do_reset();
      t_every();
      t_reclear();
      t_fill();
      test_done();
   end
endmodule
